// file: hdl/fsp_sequencer.sv
// flash self-programming sequencer top
//
// Contract
// - erase command plus store within four cycles
// - load command stores data word to slot
// - write command programs buffer into page
// - lock set takes data low register
// - pointer low bits word, high bits page
// - address latched when operation starts
// - lock set ignores the pointer
// - reads use byte select; stores ignore it
// - erase uses only page index
// - halting region target stalls the cpu
// - buffer clears on write, re-enable, reset
// - eeprom write during loading discards buffer
// - ready interrupt while enabled and idle
// - busy blocks concurrent region reads
// - zero data bits 5..2 program lock bits
// - lock programming keeps all flash readable
// - eeprom write blocks all self-programming
// - enable clears after load/re-enable store, at operation end, or five cycles after a command with no store
// - buffer load clears busy status
// - other command patterns do nothing
`timescale 1ns/1ps
`default_nettype none
module fsp_sequencer
    import fsp_pkg::*;
#(
    parameter int WORDS_W = 5,    // word index width
    parameter int PAGE_W  = 8,    // page index width
    parameter int HALT_PAGE_MIN = 192, // first page of the halting region
    parameter int OP_CYC  = 64    // cycles one flash operation takes
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,             // clock enable
    input  wire logic        i_ctl_we,         // cpu writes control register
    input  wire logic [7:0]  i_ctl_wdata,      // written value
    output logic      [7:0]  o_ctl_rdata,      // control/status readback
    input  wire logic        i_store_instr,    // store instruction pulse
    input  wire logic [15:0] i_ptr,            // address pointer
    input  wire logic [7:0]  i_data_low,       // data low register
    input  wire logic [7:0]  i_data_high,      // data high register
    input  wire logic        i_eeprom_write_flag, // eeprom busy
    input  wire logic        i_read_req,       // cpu program read
    input  wire logic [15:0] i_read_addr,      // byte address of read
    output logic             o_read_blocked,   // read refused
    output logic [15:0]      o_flash_word_addr,// word address for read
    output logic             o_flash_byte_sel, // byte select of read
    output logic             o_cpu_halt,       // stall cpu
    output logic             o_irq,            // ready interrupt
    output logic             o_flash_erase,    // erase strobe
    output logic             o_flash_write,    // write strobe
    output logic [PAGE_W-1:0] o_flash_page,    // latched page
    output logic [3:0]       o_lock_prog,      // lock bits to program
    output logic             o_lock_strobe,    // lock program pulse
    output logic [15:0]      o_buf_word,       // buffer word for flash
    input  wire logic [WORDS_W-1:0] i_buf_rd_idx // buffer slot requested
);
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_BUSY
    } fsp_state_e;

    fsp_state_e        state_r;       // sequencer state
    logic [4:0]        cmd_r;         // command pattern held in window
    logic              irqen_r;       // interrupt enable bit
    logic              busy_r;        // region busy bit
    logic              halt_r;        // operation targets halting region
    fsp_op_e           op_r;          // operation in progress
    logic [15:0]       cnt_r;         // operation timer
    logic              win_open;      // store window open
    logic              arm;           // valid command accepted
    logic              take;          // store instruction taken
    logic              buf_wr;        // load buffer word
    logic              buf_clr;       // clear buffer
    logic              loading_r;     // buffer holds partial load
    logic [PAGE_W-1:0] page_idx;      // page field of pointer
    logic [WORDS_W-1:0] word_idx;     // word field of pointer
    logic [PAGE_W-1:0] rd_page;       // page field of read address
    logic              valid_cmd;     // written pattern is a known command
    logic              op_done;       // timer expired

    localparam logic [15:0] OP_LAST = 16'(OP_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // pointer split: bit 0 byte select, then word, then page
    assign word_idx = i_ptr[WORDS_W:1];
    assign page_idx = i_ptr[WORDS_W+PAGE_W:WORDS_W+1];
    assign rd_page  = i_read_addr[WORDS_W+PAGE_W:WORDS_W+1];

    // only the five listed patterns count; eeprom write blocks all
    always_comb begin
        case (i_ctl_wdata[4:0])
            CMD_LOAD, CMD_ERASE, CMD_WRITE,
            CMD_LOCK, CMD_REEN: valid_cmd = 1'b1;
            default:            valid_cmd = 1'b0;
        endcase
    end
    assign arm  = i_ctl_we && valid_cmd && state_r != FSP_BUSY &&
                  !i_eeprom_write_flag;
    assign take = i_store_instr && win_open && state_r == FSP_ARMED &&
                  !arm && !i_eeprom_write_flag;
    assign buf_wr = take && cmd_r == CMD_LOAD;
    assign op_done = state_r == FSP_BUSY && cnt_r == OP_LAST;
    // clear after write, on re-enable, or when eeprom breaks a load
    assign buf_clr = (op_done && op_r == FSP_OP_WRITE) ||
                     (take && cmd_r == CMD_REEN) ||
                     (loading_r && i_eeprom_write_flag);

    ////////////////////////////////////////////////////////////////////
    // window timer
    fsp_cmd_window u_win (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_ce      (i_ce),
        .i_arm     (arm),
        .i_consume (take),
        .o_open    (win_open)
    );

    ////////////////////////////////////////////////////////////////////
    // temporary page buffer
    fsp_page_buf #(
        .WORDS_W (WORDS_W)
    ) u_buf (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_ce      (i_ce),
        .i_wr      (buf_wr),
        .i_idx     (word_idx),
        .i_data    ({i_data_high, i_data_low}),
        .i_clear   (buf_clr),
        .i_rd_idx  (i_buf_rd_idx),
        .o_rd_data (o_buf_word)
    );

    ////////////////////////////////////////////////////////////////////
    // main state machine: idle, armed window, busy operation
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= FSP_IDLE;
            cmd_r   <= 5'h00;
            op_r    <= FSP_OP_ERASE;
            cnt_r   <= 16'h0000;
        end else if (i_ce) begin
            case (state_r)
                FSP_IDLE: begin
                    if (arm) begin
                        state_r <= FSP_ARMED;
                        cmd_r   <= i_ctl_wdata[4:0];
                    end
                end
                FSP_ARMED: begin
                    if (arm) begin
                        cmd_r <= i_ctl_wdata[4:0]; // newest command wins
                    end else if (take) begin
                        cnt_r <= 16'h0000;
                        case (cmd_r)
                            CMD_ERASE: begin
                                state_r <= FSP_BUSY;
                                op_r    <= FSP_OP_ERASE;
                            end
                            CMD_WRITE: begin
                                state_r <= FSP_BUSY;
                                op_r    <= FSP_OP_WRITE;
                            end
                            CMD_LOCK: begin
                                state_r <= FSP_BUSY;
                                op_r    <= FSP_OP_LOCK;
                            end
                            default: begin
                                state_r <= FSP_IDLE;
                            end
                        endcase
                    end else if (!win_open) begin
                        state_r <= FSP_IDLE;
                    end
                end
                FSP_BUSY: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (op_done) begin
                        state_r <= FSP_IDLE;
                    end
                end
                default: state_r <= FSP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address and lock data latched at the start of an operation
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_flash_page <= '0;
            o_lock_prog  <= 4'h0;
            halt_r       <= 1'b0;
        end else if (i_ce && take) begin
            if (cmd_r == CMD_ERASE || cmd_r == CMD_WRITE) begin
                o_flash_page <= page_idx;
                halt_r <= 32'(page_idx) >= HALT_PAGE_MIN;
            end
            if (cmd_r == CMD_LOCK) begin
                // pointer is not looked at; zero bits program lock bits
                o_lock_prog <= ~i_data_low[LOCK_LSB+LOCK_W-1:LOCK_LSB];
                halt_r      <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one-cycle strobes to the flash array
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_flash_erase <= 1'b0;
            o_flash_write <= 1'b0;
            o_lock_strobe <= 1'b0;
        end else if (i_ce) begin
            o_flash_erase <= take && cmd_r == CMD_ERASE;
            o_flash_write <= take && cmd_r == CMD_WRITE;
            o_lock_strobe <= take && cmd_r == CMD_LOCK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // region busy: set by erase/write to the concurrent region
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_r <= 1'b0;
        end else if (i_ce) begin
            if (take && (cmd_r == CMD_ERASE || cmd_r == CMD_WRITE) &&
                32'(page_idx) < HALT_PAGE_MIN) begin
                busy_r <= 1'b1;
            end else if (take && (cmd_r == CMD_LOAD || cmd_r == CMD_REEN)) begin
                busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // partial-load tracker for the eeprom discard case
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            loading_r <= 1'b0;
        end else if (i_ce) begin
            if (buf_clr) begin
                loading_r <= 1'b0;
            end else if (buf_wr) begin
                loading_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt enable bit
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irqen_r <= CTL_RESET[CTL_IRQEN_BIT];
        end else if (i_ce && i_ctl_we) begin
            irqen_r <= i_ctl_wdata[CTL_IRQEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // readback and outputs
    always_comb begin
        o_ctl_rdata = CTL_RESET;
        o_ctl_rdata[CTL_EN_BIT] = state_r != FSP_IDLE;
        if (state_r != FSP_IDLE) begin
            o_ctl_rdata[CTL_ERASE_BIT] = cmd_r[CTL_ERASE_BIT];
            o_ctl_rdata[CTL_WRITE_BIT] = cmd_r[CTL_WRITE_BIT];
            o_ctl_rdata[CTL_LOCK_BIT]  = cmd_r[CTL_LOCK_BIT];
            o_ctl_rdata[CTL_REEN_BIT]  = cmd_r[CTL_REEN_BIT];
        end
        o_ctl_rdata[CTL_BUSY_BIT]  = busy_r;
        o_ctl_rdata[CTL_IRQEN_BIT] = irqen_r;
    end

    // level interrupt whenever enabled and enable bit reads clear
    assign o_irq = irqen_r && state_r == FSP_IDLE;
    // stall cpu only for erase/write aimed at halting region
    assign o_cpu_halt = state_r == FSP_BUSY && halt_r &&
                        op_r != FSP_OP_LOCK;
    // busy blocks only concurrent-region reads; halting region stays open
    assign o_read_blocked = i_read_req && busy_r &&
                            32'(rd_page) < HALT_PAGE_MIN;
    assign o_flash_word_addr = {1'b0, i_read_addr[15:1]};
    assign o_flash_byte_sel  = i_read_addr[0];
endmodule
`default_nettype wire

// file: hdl/fsp_pkg.sv
// package: constants for the flash self-programming sequencer
package fsp_pkg;
    // control register bit positions
    localparam int CTL_EN_BIT      = 0;
    localparam int CTL_ERASE_BIT   = 1;
    localparam int CTL_WRITE_BIT   = 2;
    localparam int CTL_LOCK_BIT    = 3;
    localparam int CTL_REEN_BIT    = 4;
    localparam int CTL_BUSY_BIT    = 6;
    localparam int CTL_IRQEN_BIT   = 7;
    // low five control bits command patterns
    localparam logic [4:0] CMD_LOAD  = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK  = 5'h09;
    localparam logic [4:0] CMD_REEN  = 5'h11;
    // store instruction window in clock cycles
    localparam logic [2:0] WINDOW_CYC = 3'h4;
    // lock bits taken from data low bits 5..2
    localparam int LOCK_LSB = 2;
    localparam int LOCK_W   = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // operation kinds
    typedef enum logic [1:0] {
        FSP_OP_ERASE,
        FSP_OP_WRITE,
        FSP_OP_LOCK
    } fsp_op_e;
endpackage

// file: hdl/fsp_cmd_window.sv
// command window: arms on a command write, expires after four cycles
`timescale 1ns/1ps
`default_nettype none
module fsp_cmd_window
    import fsp_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic       i_arm,       // command accepted this cycle
    input  wire logic       i_consume,   // store instruction taken
    output logic            o_open       // window still open
);
    logic [2:0] cnt_r;  // cycles left in the window

    ////////////////////////////////////////////////////////////////////
    // countdown; re-arm wins over consume and expiry
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= 3'h0;
        end else if (i_ce) begin
            if (i_arm) begin
                cnt_r <= WINDOW_CYC;
            end else if (i_consume) begin
                cnt_r <= 3'h0;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end

    assign o_open = (cnt_r != 3'h0);
endmodule
`default_nettype wire

// file: hdl/fsp_page_buf.sv
// temporary page buffer with per-slot loaded flags
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buf #(
    parameter int WORDS_W = 5
) (
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_ce,
    input  wire logic               i_wr,     // load one word
    input  wire logic [WORDS_W-1:0] i_idx,    // slot index
    input  wire logic [15:0]        i_data,   // word to store
    input  wire logic               i_clear,  // discard all contents
    input  wire logic [WORDS_W-1:0] i_rd_idx, // read slot
    output logic      [15:0]        o_rd_data // slot contents
);
    localparam int N = 1 << WORDS_W;
    logic [15:0] mem_r [N];   // buffer words
    logic [N-1:0] vld_r;      // slot loaded since last clear

    ////////////////////////////////////////////////////////////////////
    // one generate entry per slot; cleared slots read as erased flash
    for (genvar g = 0; g < N; g++) begin : g_slot
        always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                mem_r[g] <= 16'hFFFF;
                vld_r[g] <= 1'b0;
            end else if (i_ce) begin
                if (i_clear) begin
                    mem_r[g] <= 16'hFFFF;
                    vld_r[g] <= 1'b0;
                end else if (i_wr && i_idx == WORDS_W'(g) && !vld_r[g]) begin
                    // a second write to a slot is dropped
                    mem_r[g] <= i_data;
                    vld_r[g] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered read port
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= 16'hFFFF;
        end else if (i_ce) begin
            o_rd_data <= mem_r[i_rd_idx];
        end
    end
endmodule
`default_nettype wire

// file: verif/fsp_cpu_model.sv
// cpu model: issues control writes and store instructions
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
    input  wire logic        i_sys_clk,
    output logic             o_we,
    output logic [7:0]       o_wdata,
    output logic             o_store,
    output logic [15:0]      o_ptr,
    output logic [7:0]       o_dlow,
    output logic [7:0]       o_dhigh
);
    // idle bus at time zero
    initial begin
        o_we    = 1'b0;
        o_wdata = 8'h00;
        o_store = 1'b0;
        o_ptr   = 16'h0000;
        o_dlow  = 8'h00;
        o_dhigh = 8'h00;
    end

    // command write, then store sampled k edges later; k = 0 sends none
    task automatic req(input logic [7:0] cmd, input logic [15:0] ptr,
                       input logic [15:0] dat, input int k);
        @(negedge i_sys_clk);
        o_we    = 1'b1;
        o_wdata = cmd;
        o_ptr   = ptr;
        {o_dhigh, o_dlow} = dat;
        @(negedge i_sys_clk);
        o_we = 1'b0;
        repeat (k - 1) @(negedge i_sys_clk);
        o_store = (k > 0);
        @(negedge i_sys_clk);
        o_store = 1'b0;
        // scramble pointer and data so stale values show up
        o_ptr   = ~ptr;
        {o_dhigh, o_dlow} = ~dat;
    endtask
endmodule
`default_nettype wire

// file: verif/fsp_seq_sva.sv
// checker: port-level properties of the self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
module fsp_seq_sva
    import fsp_pkg::*;
#(
    parameter int PAGE_W        = 8,
    parameter int HALT_PAGE_MIN = 192
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ctl_we,
    input  wire logic [7:0]        o_ctl_rdata,
    input  wire logic              i_store_instr,
    input  wire logic [7:0]        i_data_low,
    input  wire logic              i_eeprom_write_flag,
    input  wire logic              i_read_req,
    input  wire logic [15:0]       i_read_addr,
    input  wire logic              o_read_blocked,
    input  wire logic              o_cpu_halt,
    input  wire logic              o_irq,
    input  wire logic              o_flash_erase,
    input  wire logic              o_flash_write,
    input  wire logic [PAGE_W-1:0] o_flash_page,
    input  wire logic [3:0]        o_lock_prog,
    input  wire logic              o_lock_strobe
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // enable and busy readback bits
    wire logic en   = o_ctl_rdata[CTL_EN_BIT];
    wire logic busy = o_ctl_rdata[CTL_BUSY_BIT];
    //////////////////////////////////////////////////////////////////////
    property p_irq_level;
        o_irq == (o_ctl_rdata[CTL_IRQEN_BIT] && !en);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("ready interrupt level wrong");
    property p_erase_cause;
        o_flash_erase |-> $past(i_store_instr);
    endproperty
    a_erase_cause: assert property (p_erase_cause)
        else $error("erase strobe without store");
    property p_write_cause;
        o_flash_write |-> $past(i_store_instr);
    endproperty
    a_write_cause: assert property (p_write_cause)
        else $error("write strobe without store");
    property p_lock_data;
        o_lock_strobe |-> o_lock_prog == ~$past(i_data_low[5:2]) && !o_cpu_halt;
    endproperty
    a_lock_data: assert property (p_lock_data)
        else $error("lock bits not from inverted data low");
    property p_blocked;
        en && busy && i_read_req && i_read_addr[13:6] < HALT_PAGE_MIN
            |-> o_read_blocked;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("busy region read not blocked");
    property p_busy_set;
        (o_flash_erase || o_flash_write) && o_flash_page < HALT_PAGE_MIN
            |-> ##[0:1] busy;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy not set for concurrent region");
    property p_halt_region;
        o_cpu_halt |-> en && o_flash_page >= HALT_PAGE_MIN;
    endproperty
    a_halt_region: assert property (p_halt_region)
        else $error("halt outside halting region operation");
    // window must expire when neither store nor new command comes
    property p_window;
        ($rose(en) ##0 (!i_store_instr && !i_ctl_we) [*5]) |=> !en;
    endproperty
    a_window: assert property (p_window)
        else $error("enable outlived the store window");
    property p_en_hold;
        (o_flash_erase || o_flash_write) |-> en [*4];
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enable dropped during operation");
    property p_eeprom_block;
        i_eeprom_write_flag |=> !(o_flash_erase || o_flash_write || o_lock_strobe);
    endproperty
    a_eeprom_block: assert property (p_eeprom_block)
        else $error("operation started during eeprom write");
    c_erase: cover property (o_flash_erase);
    c_write: cover property (o_flash_write);
    c_lock: cover property (o_lock_strobe);
endmodule
`default_nettype wire

// file: verif/flash_self_program_sequencer_test.sv
// testbench: random and corner-case traffic through the sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_test
    import fsp_pkg::*;
;
    logic clk, rst_b, we, store, ee, rd_req, rd_blk, halt, irq, ers, wrt;
    logic lstb, bsel;
    logic [7:0]  wdata, rdata, d_lo, d_hi, page, p;
    logic [15:0] ptr, rd_addr, waddr, bword;
    logic [3:0]  lock;
    logic [4:0]  bidx;
    logic [31:0] r;
    logic [15:0] w [4];
    logic [4:0]  bad [5] = '{5'h00, 5'h07, 5'h0B, 5'h13, 5'h1F};
    int fail_count, compares, cyc, n_ers, n_wrt, n_lck, seed;

    fsp_sequencer #(.OP_CYC(8)) fsp_sequencer_i (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_ctl_we(we),
        .i_ctl_wdata(wdata), .o_ctl_rdata(rdata), .i_store_instr(store),
        .i_ptr(ptr), .i_data_low(d_lo), .i_data_high(d_hi),
        .i_eeprom_write_flag(ee), .i_read_req(rd_req), .i_read_addr(rd_addr),
        .o_read_blocked(rd_blk), .o_flash_word_addr(waddr),
        .o_flash_byte_sel(bsel), .o_cpu_halt(halt), .o_irq(irq),
        .o_flash_erase(ers), .o_flash_write(wrt), .o_flash_page(page),
        .o_lock_prog(lock), .o_lock_strobe(lstb), .o_buf_word(bword),
        .i_buf_rd_idx(bidx));
    fsp_cpu_model fsp_cpu_model_i (
        .i_sys_clk(clk), .o_we(we), .o_wdata(wdata), .o_store(store),
        .o_ptr(ptr), .o_dlow(d_lo), .o_dhigh(d_hi));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count strobes at the falling edge, where outputs have settled
    always @(negedge clk) begin
        n_ers += (ers === 1'b1);
        n_wrt += (wrt === 1'b1);
        n_lck += (lstb === 1'b1);
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    //////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // bounded wait for the enable bit to drop
    task automatic idle;
        for (int k = 0; k < 40 && rdata[CTL_EN_BIT] !== 1'b0; k++)
            @(negedge clk);
    endtask
    // select a buffer slot; the word appears one edge later
    task automatic sel(input logic [4:0] i);
        bidx = i;
        @(negedge clk);
    endtask
    // pointer layout: page above word index above byte select
    function automatic logic [15:0] zp(input logic [7:0] pg,
                                       input logic [4:0] wd, input logic b);
        return {2'b00, pg, wd, b};
    endfunction
    //////////////////////////////////////////////////////////////////////
    initial begin
        seed = 1;
        rst_b = 1'b0;
        ee = 1'b0;
        rd_req = 1'b0;
        rd_addr = 16'h0000;
        bidx = 5'h00;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check(rdata, CTL_RESET);
        check(bword, 16'hFFFF);
        // fill four slots once each, byte select random
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            w[i] = r[15:0];
            fsp_cpu_model_i.req({3'h0, CMD_LOAD}, zp(8'h10, 5'(i), r[16]),
                                w[i], 1);
        end
        for (int i = 0; i < 4; i++) begin
            sel(5'(i));
            check(bword, w[i]);
        end
        // erase with store on the last window edge, stray pointer bits
        r = $random(seed);
        p = r[7:0] % 8'd192;
        fsp_cpu_model_i.req({3'h4, CMD_ERASE}, {r[31:30], p, r[21:16]},
                            r[15:0], 4);
        check(page, p);
        @(negedge clk);
        check(rdata[CTL_BUSY_BIT], 1'b1);
        rd_req = 1'b1;
        rd_addr = zp(p, r[4:0], 1'b1);
        #1 check(rd_blk, 1'b1);
        check(waddr, {1'b0, rd_addr[15:1]});
        check(bsel, 1'b1);
        check(halt, 1'b0);
        rd_req = 1'b0;
        idle();
        check(irq, 1'b1);
        check(n_ers, 1);
        // one load clears busy; then write the same page
        fsp_cpu_model_i.req({3'h0, CMD_LOAD}, zp(p, 5'h04, 1'b0), 16'h1234, 2);
        check(rdata[CTL_BUSY_BIT], 1'b0);
        fsp_cpu_model_i.req({3'h0, CMD_WRITE}, zp(p, 5'h00, 1'b0), r[15:0],
                            3);
        check(page, p);
        idle();
        check(n_wrt, 1);
        sel(5'h04);
        check(bword, 16'hFFFF);
        // re-enable empties a freshly loaded slot; busy, cleared by that load, stays clear
        fsp_cpu_model_i.req({3'h0, CMD_LOAD}, zp(p, 5'h03, 1'b0), 16'h5A5A, 1);
        fsp_cpu_model_i.req({3'h0, CMD_REEN}, 16'h0000, 16'h0000, 1);
        idle();
        check(rdata[CTL_BUSY_BIT], 1'b0);
        sel(5'h03);
        check(bword, 16'hFFFF);
        // erase in the halting region stalls the cpu
        r = $random(seed);
        p = 8'd192 + {2'b00, r[5:0]};
        fsp_cpu_model_i.req({3'h0, CMD_ERASE}, zp(p, r[12:8], 1'b0), 16'h0, 1);
        @(negedge clk);
        check(halt, 1'b1);
        idle();
        check(halt, 1'b0);
        // lock set with random pointer, spare data bits one
        r = $random(seed);
        fsp_cpu_model_i.req({3'h0, CMD_LOCK}, r[31:16],
                            {r[15:8], 2'b11, r[5:2], 2'b11}, 2);
        check(lock, 4'(~r[5:2]));
        check(halt, 1'b0);
        idle();
        check(n_lck, 1);
        // no store, then a store one edge past the window
        fsp_cpu_model_i.req({3'h0, CMD_ERASE}, 16'h0040, 16'h0, 0);
        repeat (5) @(negedge clk);
        check(rdata[CTL_EN_BIT], 1'b0);
        fsp_cpu_model_i.req({3'h0, CMD_ERASE}, 16'h0040, 16'h0, 5);
        check(n_ers, 2);
        // patterns outside the command set do nothing
        foreach (bad[i]) begin
            fsp_cpu_model_i.req({3'h0, bad[i]}, 16'h0080, 16'hFFFF, 1);
            check(rdata[CTL_EN_BIT], 1'b0);
        end
        check(n_ers + n_wrt + n_lck, 4);
        // eeprom write amid loading drops the buffer and blocks commands
        fsp_cpu_model_i.req({3'h0, CMD_LOAD}, zp(8'h02, 5'h01, 1'b0), w[1], 1);
        ee = 1'b1;
        fsp_cpu_model_i.req({3'h0, CMD_ERASE}, 16'h0040, 16'h0, 1);
        check(rdata[CTL_EN_BIT], 1'b0);
        ee = 1'b0;
        sel(5'h01);
        check(bword, 16'hFFFF);
        check(n_ers, 2);
        tally_and_finish();
    end
endmodule

bind fsp_sequencer fsp_seq_sva #(
    .PAGE_W(PAGE_W), .HALT_PAGE_MIN(HALT_PAGE_MIN)
) fsp_seq_sva_i (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ctl_we(i_ctl_we),
    .o_ctl_rdata(o_ctl_rdata), .i_store_instr(i_store_instr),
    .i_data_low(i_data_low), .i_eeprom_write_flag(i_eeprom_write_flag),
    .i_read_req(i_read_req), .i_read_addr(i_read_addr),
    .o_read_blocked(o_read_blocked), .o_cpu_halt(o_cpu_halt), .o_irq(o_irq),
    .o_flash_erase(o_flash_erase), .o_flash_write(o_flash_write),
    .o_flash_page(o_flash_page), .o_lock_prog(o_lock_prog),
    .o_lock_strobe(o_lock_strobe));
`default_nettype wire
